// file: verilog/rsc_reset_combiner.sv
// Contract
// - any active reset source asserts the single system reset output
// - sources: power-on, brown-out, pin, instruction, watchdog, mismatch, trap, illegal
// - each reset type sets its own flag in the cause register
// - power-on reset clears all set flags except the power-on and brown-out flags
// - software may set or clear flags; writing never causes a reset
// - bit 15 set on trap conflict reset
// - bit 14 set on illegal opcode, address mode or uninitialised pointer
// - bit 9 set on configuration mismatch reset
// - bit 8 keeps the regulator active in sleep when one
// - bit 7 set on master clear pin reset
// - bit 6 set when the reset instruction executes
// - bit 5 enables watchdog; fuse at one forces it enabled
// - bit 4 set on watchdog time-out
// - bit 3 set after sleep, bit 2 set after idle
// - bit 1 set on brown-out, bit 0 on power-on
// - after power-on reset only bits 1 and 0 read one
// - bits 13 to 10 read zero and ignore writes
// - power-on and brown-out are cold resets, all others warm
module rsc_reset_combiner (
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // asynchronous sources from pins and analog
   input  wire logic        power_on_src,
   input  wire logic        brown_out_src,
   input  wire logic        master_clear_pin_n,
   input  wire logic        fuse_watchdog_enable,
   // same-clock sources from the core
   input  wire logic        reset_instr,
   input  wire logic        watchdog_timeout,
   input  wire logic        config_mismatch,
   input  wire logic        trap_conflict,
   input  wire logic        illegal_opcode,
   input  wire logic        uninit_w_access,
   input  wire logic        security_violation,
   input  wire logic        sleep_entered,
   input  wire logic        idle_entered,
   // results
   output logic             system_reset,
   output logic             cold_reset,
   output logic             watchdog_enable,
   output logic             regulator_sleep_active
);

   ////////////////////////////////////////////////////////////////////////
   // synchronise pin sources

   logic [rsc_pkg::PIN_SRC_W-1:0] pin_sync;
   logic por_s;
   logic brown_s;
   logic pin_rst_s;
   logic fuse_s;

   // the pin is active low, so it is turned round ahead of the first stage
   rsc_sync2 #(
      .W (rsc_pkg::PIN_SRC_W)
   ) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({fuse_watchdog_enable, ~master_clear_pin_n, brown_out_src, power_on_src}),
      .sync_out (pin_sync)
   );

   assign por_s     = pin_sync[0];
   assign brown_s   = pin_sync[1];
   assign pin_rst_s = pin_sync[2];
   assign fuse_s    = pin_sync[3];

   ////////////////////////////////////////////////////////////////////////
   // apb access decode

   logic        addr_hit;
   logic        wr_go;
   logic [15:0] wr_mask;
   logic [15:0] cause_r;
   logic [15:0] cause_nxt;
   logic [31:0] prdata_nxt;
   logic        pready_nxt;
   logic        pslverr_nxt;

   assign addr_hit = (paddr == rsc_pkg::CAUSE_OFFSET);
   // write lands on the access edge, when pready is already high
   assign wr_go    = psel && penable && pready && pwrite && addr_hit;
   assign wr_mask  = {{8{pstrb[1]}}, {8{pstrb[0]}}} & rsc_pkg::CAUSE_IMPL;

   // answer prepared in the setup cycle so every bus output is a flop
   always_comb begin
      pready_nxt  = psel && !penable;
      pslverr_nxt = psel && !penable && !addr_hit;
      prdata_nxt  = 32'h0000_0000;
      if (psel && !penable && addr_hit && !pwrite) begin
         prdata_nxt = {16'h0000, cause_r};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= pready_nxt;
         pslverr <= pslverr_nxt;
         prdata  <= prdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reset cause register

   logic        wdog_en_nxt;
   logic        illegal_any;
   logic        warm_any;
   logic [15:0] set_vec;

   assign wdog_en_nxt = cause_r[rsc_pkg::SWDT_EN_BIT] || fuse_s;
   assign illegal_any = illegal_opcode || uninit_w_access || security_violation;
   // all warm sources; a disabled watchdog cannot time out
   assign warm_any    = pin_rst_s || reset_instr || (watchdog_timeout && watchdog_enable)
                        || config_mismatch || trap_conflict || illegal_any;

   always_comb begin
      set_vec = 16'h0000;
      set_vec[rsc_pkg::BROWN_BIT]   = brown_s;
      set_vec[rsc_pkg::IDLE_BIT]    = idle_entered;
      set_vec[rsc_pkg::SLEEP_BIT]   = sleep_entered;
      set_vec[rsc_pkg::WDOG_TO_BIT]  = watchdog_timeout && watchdog_enable;
      set_vec[rsc_pkg::INSTR_BIT]    = reset_instr;
      set_vec[rsc_pkg::PIN_BIT]      = pin_rst_s;
      set_vec[rsc_pkg::MISMATCH_BIT] = config_mismatch;
      set_vec[rsc_pkg::ILLEGAL_BIT] = illegal_any;
      set_vec[rsc_pkg::TRAP_BIT]    = trap_conflict;
   end

   // flags sticky, a set beats a same-cycle clear
   always_comb begin
      cause_nxt = cause_r;
      if (wr_go) begin
         cause_nxt = (cause_r & ~wr_mask) | (pwdata[15:0] & wr_mask);
      end
      cause_nxt = cause_nxt | set_vec;
      // power-on wipes all but its own flag and the brown-out flag
      if (por_s) begin
         cause_nxt = rsc_pkg::CAUSE_RESET;
      end
      cause_nxt = cause_nxt & rsc_pkg::CAUSE_IMPL;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_r <= rsc_pkg::CAUSE_RESET;
      end else begin
         cause_r <= cause_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // system reset, cold flag and control outputs

   logic sys_rst_nxt;
   logic cold_nxt;

   always_comb begin
      sys_rst_nxt = por_s || brown_s || warm_any;
      // cold only for power-on or brown-out
      cold_nxt    = por_s || brown_s;
   end

   // reset held asserted by presetn itself, as power-on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         system_reset           <= 1'b1;
         cold_reset             <= 1'b1;
         watchdog_enable        <= 1'b0;
         regulator_sleep_active <= 1'b0;
      end else begin
         system_reset           <= sys_rst_nxt;
         cold_reset             <= cold_nxt;
         watchdog_enable        <= wdog_en_nxt;
         regulator_sleep_active <= cause_r[rsc_pkg::VREG_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions

   sequence flag_write_s;
      psel && penable && pready && pwrite && addr_hit && pstrb[0];
   endsequence

   sequence quiet_s;
      !por_s && !brown_s && !warm_any;
   endsequence

   property flag_sets_p(logic src, int idx);
      @(posedge pclk) disable iff (!presetn)
         (src && !por_s) |=> cause_r[idx];
   endproperty

   system_reset_any_src_a : assert property (@(posedge pclk) disable iff (!presetn)
      (por_s || brown_s || warm_any) |=> system_reset)
      else $error("system reset missed an active source");

   system_reset_release_a : assert property (@(posedge pclk) disable iff (!presetn)
      quiet_s [*2] |=> !system_reset)
      else $error("system reset held with no source");

   por_wipe_a : assert property (@(posedge pclk) disable iff (!presetn)
      por_s |=> (cause_r == rsc_pkg::CAUSE_RESET))
      else $error("power-on did not restore cause register");

   write_no_reset_a : assert property (@(posedge pclk) disable iff (!presetn)
      (flag_write_s and quiet_s) ##1 quiet_s |=> !system_reset)
      else $error("software write caused a reset");

   write_stores_a : assert property (@(posedge pclk) disable iff (!presetn)
      (flag_write_s and (!por_s && !brown_s && set_vec == 16'h0000))
      |=> cause_r[7:0] == $past(pwdata[7:0]))
      else $error("flag write not stored");

   trap_flag_a : assert property (flag_sets_p(trap_conflict, rsc_pkg::TRAP_BIT))
      else $error("trap flag not set");

   illegal_flag_a : assert property (flag_sets_p(illegal_any, rsc_pkg::ILLEGAL_BIT))
      else $error("illegal flag not set");

   mismatch_flag_a : assert property (flag_sets_p(config_mismatch, rsc_pkg::MISMATCH_BIT))
      else $error("mismatch flag not set");

   vreg_out_a : assert property (@(posedge pclk) disable iff (!presetn)
      regulator_sleep_active == $past(cause_r[rsc_pkg::VREG_BIT]))
      else $error("regulator output does not follow bit 8");

   pin_flag_a : assert property (flag_sets_p(pin_rst_s, rsc_pkg::PIN_BIT))
      else $error("pin flag not set");

   instr_flag_a : assert property (flag_sets_p(reset_instr, rsc_pkg::INSTR_BIT))
      else $error("instruction flag not set");

   wdog_enable_a : assert property (@(posedge pclk) disable iff (!presetn)
      fuse_s |=> watchdog_enable)
      else $error("fuse did not force watchdog on");

   wdog_flag_a : assert property (@(posedge pclk) disable iff (!presetn)
      (watchdog_timeout && watchdog_enable && !por_s) |=> cause_r[rsc_pkg::WDOG_TO_BIT])
      else $error("watchdog flag not set");

   sleep_flag_a : assert property (flag_sets_p(sleep_entered, rsc_pkg::SLEEP_BIT))
      else $error("sleep flag not set");

   brown_flag_a : assert property (flag_sets_p(brown_s, rsc_pkg::BROWN_BIT))
      else $error("brown-out flag not set");

   unimpl_zero_a : assert property (@(posedge pclk) disable iff (!presetn)
      cause_r[13:10] == 4'h0)
      else $error("unimplemented bits not zero");

   cold_warm_a : assert property (@(posedge pclk) disable iff (!presetn)
      (warm_any && !por_s && !brown_s) |=> (system_reset && !cold_reset))
      else $error("warm source flagged as cold");

   sticky_flag_a : assert property (@(posedge pclk) disable iff (!presetn)
      (cause_r[rsc_pkg::PIN_BIT] && !wr_go && !por_s) |=> cause_r[rsc_pkg::PIN_BIT])
      else $error("pin flag lost without a clear");

endmodule

// file: pkg/rsc_pkg.sv
package rsc_pkg;

   // register map
   localparam logic [11:0] CAUSE_OFFSET = 12'h000;

   // field positions of reset_cause_reg
   localparam int POR_BIT       = 0;
   localparam int BROWN_BIT     = 1;
   localparam int IDLE_BIT      = 2;
   localparam int SLEEP_BIT     = 3;
   localparam int WDOG_TO_BIT   = 4;
   localparam int SWDT_EN_BIT   = 5;
   localparam int INSTR_BIT     = 6;
   localparam int PIN_BIT       = 7;
   localparam int VREG_BIT      = 8;
   localparam int MISMATCH_BIT  = 9;
   localparam int ILLEGAL_BIT   = 14;
   localparam int TRAP_BIT      = 15;

   // value after a power-on reset, and bits that exist
   localparam logic [15:0] CAUSE_RESET = 16'h0003;
   localparam logic [15:0] CAUSE_IMPL  = 16'hc3ff;

   // width of the synchronised pin group
   localparam int PIN_SRC_W = 4;

endpackage

// file: verilog/rsc_sync2.sv
// two-stage synchroniser for a group of level inputs
module rsc_sync2 #(
   parameter int W = 1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] sync_nxt;

   // first stage feeds only the second stage
   always_comb begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= meta_nxt;
         sync_out <= sync_nxt;
      end
   end

endmodule

// file: tb/rsc_reset_combiner_tb.sv
module rsc_reset_combiner_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        power_on_src;
   logic        brown_out_src;
   logic        master_clear_pin_n;
   logic        fuse_watchdog_enable;
   logic [8:0]  core_src;
   logic        system_reset;
   logic        cold_reset;
   logic        watchdog_enable;
   logic        regulator_sleep_active;
   int          n_fail;
   int          n_tests;
   logic [31:0] rd;
   logic        rd_err;
   logic [31:0] exp_v;
   int          src_bit [9] = '{6, 4, 9, 15, 14, 14, 14, 3, 2};

   rsc_reset_combiner dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .power_on_src(power_on_src), .brown_out_src(brown_out_src),
      .master_clear_pin_n(master_clear_pin_n), .fuse_watchdog_enable(fuse_watchdog_enable),
      .reset_instr(core_src[0]), .watchdog_timeout(core_src[1]),
      .config_mismatch(core_src[2]), .trap_conflict(core_src[3]),
      .illegal_opcode(core_src[4]), .uninit_w_access(core_src[5]),
      .security_violation(core_src[6]), .sleep_entered(core_src[7]),
      .idle_entered(core_src[8]), .system_reset(system_reset), .cold_reset(cold_reset),
      .watchdog_enable(watchdog_enable), .regulator_sleep_active(regulator_sleep_active)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // clock at 50 mhz
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // compare one value, count it
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task stop_test;
      if (n_fail == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // apb transfer; request held until pready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog process ends a wait that never gets an answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      rd_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task rd_cause(input string nm, input logic [31:0] exp);
      apb(1'b0, 12'h000, 32'h0000_0000, 4'hf);
      chk(nm, rd, exp);
   endtask

   // hung handshake guard, run needs well under this
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      stop_test();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      n_fail = 0;
      n_tests = 0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {power_on_src, brown_out_src, fuse_watchdog_enable} = '0;
      master_clear_pin_n = 1'b1;
      core_src = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      #1 chk("system_reset", system_reset, 32'h0);
      rd_cause("cause after por", 32'h0000_0003);
      // software sets every flag; no reset may follow
      apb(1'b1, 12'h000, 32'hffff_ffff, 4'hf);
      rd_cause("cause all ones", 32'h0000_c3ff);
      chk("system_reset sw", system_reset, 32'h0);
      chk("watchdog enable", watchdog_enable, 32'h1);
      chk("regulator", regulator_sleep_active, 32'h1);
      apb(1'b1, 12'h000, 32'h0000_0000, 4'hf);
      rd_cause("cause cleared", 32'h0);
      chk("watchdog disable", watchdog_enable, 32'h0);
      // low byte lane only
      apb(1'b1, 12'h000, 32'h0000_ffff, 4'h1);
      rd_cause("cause low byte", 32'h0000_00ff);
      chk("mapped error", {31'h0, rd_err}, 32'h0);
      apb(1'b1, 12'h000, 32'h0000_0000, 4'hf);
      // a time-out with the watchdog disabled is ignored
      @(posedge pclk);
      core_src <= 9'h002;
      @(posedge pclk);
      core_src <= '0;
      #1 chk("disabled timeout reset", system_reset, 32'h0);
      rd_cause("disabled timeout flag", 32'h0);
      // fuse forces the watchdog on with the soft bit clear
      fuse_watchdog_enable <= 1'b1;
      repeat (5) @(posedge pclk);
      #1 chk("watchdog fuse", watchdog_enable, 32'h1);
      // core sources one by one, flags accumulate without clearing
      exp_v = '0;
      for (int i = 0; i < 9; i++) begin
         @(posedge pclk);
         core_src <= 9'h001 << i;
         @(posedge pclk);
         core_src <= '0;
         #1 chk("core system_reset", system_reset, (i < 7));
         chk("core cold_reset", cold_reset, 32'h0);
         exp_v[src_bit[i]] = 1'b1;
         rd_cause("core flag", exp_v);
      end
      // master clear pin, a warm reset
      @(posedge pclk);
      master_clear_pin_n <= 1'b0;
      repeat (4) @(posedge pclk);
      #1 chk("pin system_reset", system_reset, 32'h1);
      chk("pin cold_reset", cold_reset, 32'h0);
      @(posedge pclk);
      master_clear_pin_n <= 1'b1;
      repeat (5) @(posedge pclk);
      exp_v[7] = 1'b1;
      rd_cause("pin flag", exp_v);
      // brown-out, a cold reset
      brown_out_src <= 1'b1;
      repeat (4) @(posedge pclk);
      #1 chk("brown-out cold_reset", cold_reset, 32'h1);
      @(posedge pclk);
      brown_out_src <= 1'b0;
      repeat (5) @(posedge pclk);
      exp_v[1] = 1'b1;
      rd_cause("brown-out flag", exp_v);
      // power-on source wipes all but the power-on and brown-out flags
      power_on_src <= 1'b1;
      repeat (4) @(posedge pclk);
      #1 chk("por system_reset", system_reset, 32'h1);
      chk("por cold_reset", cold_reset, 32'h1);
      @(posedge pclk);
      power_on_src <= 1'b0;
      repeat (5) @(posedge pclk);
      rd_cause("cause after por src", 32'h0000_0003);
      // software clears the flags once read
      apb(1'b1, 12'h000, 32'h0000_0000, 4'hf);
      rd_cause("cause cleared after read", 32'h0);
      // unmapped address refused, a write there changes nothing
      apb(1'b0, 12'h004, 32'h0, 4'hf);
      chk("unmapped data", rd, 32'h0);
      chk("unmapped read error", {31'h0, rd_err}, 32'h1);
      apb(1'b1, 12'h004, 32'hffff_ffff, 4'hf);
      chk("unmapped write error", {31'h0, rd_err}, 32'h1);
      rd_cause("cause after unmapped write", 32'h0);
      chk("unmapped write reset", system_reset, 32'h0);
      // second reset in mid-run
      apb(1'b1, 12'h000, 32'h0000_c3fc, 4'hf);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      rd_cause("cause after reset", 32'h0000_0003);
      stop_test();
   end
endmodule
